//--- dpac_params.svh
// Purpose: Offsets, field positions, reset values and counts for dpac
// Assumes: Included by bare name; definitions only
// Notes: Register index times four gives the AHB byte address
`ifndef DPAC_PARAMS_SVH
`define DPAC_PARAMS_SVH

// ***************************************************
// Register indices (byte address = index * 4)
// ***************************************************
`define DPAC_IDX_AUX 8'h8E
`define DPAC_IDX_AUX1 8'hA2
`define DPAC_IDX_CLK 8'hB0
`define DPAC_IDX_PTR0 8'hB1
`define DPAC_IDX_PTR1 8'hB2
`define DPAC_IDX_TOGGLE 8'hB3
`define DPAC_IDX_CURPTR 8'hB4

// ***************************************************
// Field positions
// ***************************************************
`define DPAC_AUX_STROBE_OFF 0
`define DPAC_AUX_RAM_SEL 1
`define DPAC_AUX1_PSEL 0
`define DPAC_AUX1_UFLAG 3
`define DPAC_CLK_DBL 0

// ***************************************************
// Reset values
// ***************************************************
`define DPAC_RST_PTR 16'h0000
`define DPAC_RST_BIT 1'b0

// ***************************************************
// Clock divisions (clocks per strobe / per machine cycle)
// ***************************************************
`define DPAC_STROBE_DIV_STD 4'h6
`define DPAC_STROBE_DIV_X2 4'h3
`define DPAC_CYCLE_DIV_STD 4'hC
`define DPAC_CYCLE_DIV_X2 4'h6

`endif

//--- dpac_pkg.sv
// Purpose: Types shared by the dpac design files
// Assumes: Constants live in dpac_params.svh
// Notes: Each module keeps all its state in one packed struct
package dpac_pkg;

   // Width of the period counters
   localparam int DPAC_DIV_W = 4;

   // Decoded register of an AHB access
   typedef enum logic [2:0] {
      REG_NONE   = 3'b000,
      REG_AUX    = 3'b001,
      REG_AUX1   = 3'b010,
      REG_CLK    = 3'b011,
      REG_PTR0   = 3'b100,
      REG_PTR1   = 3'b101,
      REG_TOGGLE = 3'b110,
      REG_CURPTR = 3'b111
   } dpac_reg_t;

   // State of the top module
   typedef struct packed {
      logic [15:0] ptr0;
      logic [15:0] ptr1;
      logic psel;
      logic uflag;
      logic strobe_off;
      logic ram_sel;
      logic dbl;
      logic skip_pend;
      logic strobe;
      logic wr_pend;
      dpac_reg_t wr_reg;
      logic [31:0] rdata;
   } dpac_state_t;

   // State of one period divider
   typedef struct packed {
      logic [DPAC_DIV_W-1:0] cnt;
      logic tick;
   } dpac_div_t;

endpackage : dpac_pkg

//--- dpac_tick_div.sv
// Purpose: Free-running divider giving one tick per programmed period
// Assumes: period is at least 1 and comes from the hclk domain
// Notes: A shortened period takes effect immediately, no wrap past it
`timescale 1ns/100ps
module dpac_tick_div (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [dpac_pkg::DPAC_DIV_W-1:0] period,
   output logic tick
);
   import dpac_pkg::*;

   dpac_div_t s_r;
   dpac_div_t s_nxt;
   logic last;

   // ***************************************************
   // Counting
   // ***************************************************
   // Compare with >= so a period change never strands the count
   always_comb begin
      s_nxt = s_r;
      last = (s_r.cnt >= (period - 1'b1));
      s_nxt.tick = last;
      s_nxt.cnt = last ? '0 : s_r.cnt + 1'b1;
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Registered tick, one cycle wide
   assign tick = s_r.tick;

endmodule : dpac_tick_div

//--- dpac_top.sv
// Purpose: Dual data pointers, aux control bits, strobe and speed control
// Assumes: Core strobes are synchronous to hclk; hclk is the oscillator
// Notes: AHB-Lite slave, zero wait states, always OKAY
`timescale 1ns/100ps
`include "dpac_params.svh"

// Operation
// RL1: Two independent 16-bit pointers, selected one used
// RL2: Select bit at bit 0, reset 0
// RL3: Increment of aux register one toggles select
// RL4: User flag bit, read/write, no side effect
// RL5: Unimplemented bits undefined; software writes zeros
// RL6: Strobe continuous at 1/6 or 1/3, else moves only
// RL7: Ram select routes external moves on or off chip
// RL8: Reset standard twelve clocks; double speed six clocks
// RL9: Double speed halves peripheral time base
// RL10: Continuous strobe skips one pulse per data access
// RL11: Select change applies to next pointer use, no waits
module dpac_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic core_aux1_inc,
   input wire logic core_ptr_load,
   input wire logic [15:0] core_ptr_data,
   input wire logic core_ptr_inc,
   input wire logic external_move,
   input wire logic code_move,
   input wire logic ext_data_access,
   output logic [15:0] data_pointer_reg,
   output logic pointer_select,
   output logic user_flag,
   output logic addr_latch_strobe,
   output logic on_chip_expanded_ram,
   output logic ext_data_sel,
   output logic double_speed,
   output logic periph_tick
);
   import dpac_pkg::*;

   dpac_state_t s_r;
   dpac_state_t s_nxt;
   logic ap_take;
   logic strobe_tick;
   logic [DPAC_DIV_W-1:0] strobe_period;
   logic [DPAC_DIV_W-1:0] cycle_period;

   // ***************************************************
   // Address decode
   // ***************************************************
   // Upper address bits must be zero, else the access is unmapped
   function automatic dpac_reg_t decode(input logic [31:0] a);
      dpac_reg_t r;
      r = REG_NONE;
      if (a[31:10] == 22'h000000) begin
         case (a[9:2])
            `DPAC_IDX_AUX: r = REG_AUX;
            `DPAC_IDX_AUX1: r = REG_AUX1;
            `DPAC_IDX_CLK: r = REG_CLK;
            `DPAC_IDX_PTR0: r = REG_PTR0;
            `DPAC_IDX_PTR1: r = REG_PTR1;
            `DPAC_IDX_TOGGLE: r = REG_TOGGLE;
            `DPAC_IDX_CURPTR: r = REG_CURPTR;
            default: r = REG_NONE;
         endcase
      end
      return r;
   endfunction : decode

   // ***************************************************
   // Read mux
   // ***************************************************
   // Reserved bits read as zero; unmapped reads give zero
   function automatic logic [31:0] read_reg(input dpac_state_t st, input dpac_reg_t r);
      logic [31:0] d;
      d = 32'h00000000;
      case (r)
         REG_AUX: begin
            d[`DPAC_AUX_STROBE_OFF] = st.strobe_off;
            d[`DPAC_AUX_RAM_SEL] = st.ram_sel;
         end
         REG_AUX1: begin
            d[`DPAC_AUX1_PSEL] = st.psel;
            d[`DPAC_AUX1_UFLAG] = st.uflag; // [RL4]
         end
         REG_CLK: d[`DPAC_CLK_DBL] = st.dbl;
         REG_PTR0: d[15:0] = st.ptr0;
         REG_PTR1: d[15:0] = st.ptr1;
         REG_CURPTR: d[15:0] = st.psel ? st.ptr1 : st.ptr0;
         default: d = 32'h00000000;
      endcase
      return d;
   endfunction : read_reg

   // Address phase is taken only when the bus is ready
   assign ap_take = hsel & htrans[1] & hready;

   // ***************************************************
   // Next-state logic
   // ***************************************************
   always_comb begin
      s_nxt = s_r;

      // Bus data phase write; reserved bits dropped, zeros advised [RL5]
      if (s_r.wr_pend) begin
         case (s_r.wr_reg)
            REG_AUX: begin
               s_nxt.strobe_off = hwdata[`DPAC_AUX_STROBE_OFF];
               s_nxt.ram_sel = hwdata[`DPAC_AUX_RAM_SEL];
            end
            REG_AUX1: begin
               s_nxt.psel = hwdata[`DPAC_AUX1_PSEL]; // [RL2]
               s_nxt.uflag = hwdata[`DPAC_AUX1_UFLAG]; // [RL4]
            end
            REG_CLK: s_nxt.dbl = hwdata[`DPAC_CLK_DBL]; // [RL8]
            REG_PTR0: s_nxt.ptr0 = hwdata[15:0];
            REG_PTR1: s_nxt.ptr1 = hwdata[15:0];
            REG_TOGGLE: s_nxt.psel = ~s_r.psel; // [RL3]
            default: s_nxt.wr_pend = 1'b0;
         endcase
      end

      // Core increment of aux register one: invert, never force [RL3]
      if (core_aux1_inc) begin
         s_nxt.psel = ~s_nxt.psel; // [RL3]
      end

      // Pointer instructions act on the selected pointer only [RL1]
      // Select read from the register, so a toggle last cycle counts [RL11]
      if (core_ptr_load) begin
         if (s_r.psel) begin
            s_nxt.ptr1 = core_ptr_data; // [RL1]
         end else begin
            s_nxt.ptr0 = core_ptr_data; // [RL1]
         end
      end else if (core_ptr_inc) begin
         if (s_r.psel) begin
            s_nxt.ptr1 = s_r.ptr1 + 16'h0001;
         end else begin
            s_nxt.ptr0 = s_r.ptr0 + 16'h0001;
         end
      end

      // Capture address phase for the next data phase
      s_nxt.wr_pend = ap_take & hwrite;
      s_nxt.wr_reg = ap_take ? decode(haddr) : REG_NONE;

      // Read data from the updated copy, so a write just before is seen
      if (ap_take && !hwrite) begin
         s_nxt.rdata = read_reg(s_nxt, decode(haddr));
      end else begin
         s_nxt.rdata = 32'h00000000;
      end

      // Pending skip: clear on the consumed tick, then a new access sets
      if (strobe_tick && s_r.skip_pend) begin
         s_nxt.skip_pend = 1'b0; // [RL10]
      end
      if (s_r.strobe_off) begin
         s_nxt.skip_pend = 1'b0;
      end else if (ext_data_access) begin
         s_nxt.skip_pend = 1'b1; // [RL10]
      end

      // Strobe: continuous minus skips, or only during moves [RL6]
      if (s_r.strobe_off) begin
         s_nxt.strobe = strobe_tick & (external_move | code_move); // [RL6]
      end else begin
         s_nxt.strobe = strobe_tick & ~s_r.skip_pend; // [RL10]
      end
   end

   // ***************************************************
   // State register
   // ***************************************************
   // Every control bit starts cleared: standard speed, pointer zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r.ptr0 <= `DPAC_RST_PTR;
         s_r.ptr1 <= `DPAC_RST_PTR;
         s_r.psel <= `DPAC_RST_BIT; // [RL2]
         s_r.uflag <= `DPAC_RST_BIT; // [RL4]
         s_r.strobe_off <= `DPAC_RST_BIT;
         s_r.ram_sel <= `DPAC_RST_BIT;
         s_r.dbl <= `DPAC_RST_BIT; // [RL8]
         s_r.skip_pend <= 1'b0;
         s_r.strobe <= 1'b0;
         s_r.wr_pend <= 1'b0;
         s_r.wr_reg <= REG_NONE;
         s_r.rdata <= 32'h00000000;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ***************************************************
   // Time bases
   // ***************************************************
   // Double speed halves both periods [RL6] [RL8]
   assign strobe_period = s_r.dbl ? `DPAC_STROBE_DIV_X2 : `DPAC_STROBE_DIV_STD; // [RL6]
   assign cycle_period = s_r.dbl ? `DPAC_CYCLE_DIV_X2 : `DPAC_CYCLE_DIV_STD; // [RL8]

   // Strobe rate divider
   dpac_tick_div u_strobe_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .period(strobe_period),
      .tick(strobe_tick)
   );

   // Machine cycle tick that timers and serial port count on [RL9]
   dpac_tick_div u_cycle_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .period(cycle_period),
      .tick(periph_tick)
   );

   // ***************************************************
   // Outputs
   // ***************************************************
   // Zero wait state slave, never an error
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_r.rdata;

   // Selected pointer, a mux of flops so no wait is added [RL1] [RL11]
   assign data_pointer_reg = s_r.psel ? s_r.ptr1 : s_r.ptr0;
   assign pointer_select = s_r.psel;
   assign user_flag = s_r.uflag;
   assign addr_latch_strobe = s_r.strobe;
   assign double_speed = s_r.dbl;

   // External moves routed by the ram select bit [RL7]
   assign on_chip_expanded_ram = external_move & ~s_r.ram_sel; // [RL7]
   assign ext_data_sel = external_move & s_r.ram_sel; // [RL7]

endmodule : dpac_top

//--- dpac_sva.sv
// Purpose: Port checks for dpac_top
// Assumes: One clock domain, async active-low reset
// Notes: Bus write data phases excluded from hold checks
`timescale 1ns/100ps
module dpac_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic core_aux1_inc,
   input wire logic external_move,
   input wire logic pointer_select,
   input wire logic user_flag,
   input wire logic addr_latch_strobe,
   input wire logic on_chip_expanded_ram,
   input wire logic ext_data_sel,
   input wire logic double_speed,
   input wire logic periph_tick
);
   // ***********************
   // Helper and properties
   // ***********************
   logic wr_q;
   // Data phase of a write, where software may legally move bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         wr_q <= 1'b0;
      else
         wr_q <= hsel && htrans[1] && hready && hwrite;
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_inc_toggle: assert property (core_aux1_inc && !wr_q |=> pointer_select != $past(pointer_select))
      else $error("select not inverted");
   a_select_hold: assert property (!core_aux1_inc && !wr_q |=> $stable(pointer_select))
      else $error("select moved unasked");
   a_flag_hold: assert property (!wr_q |=> $stable({user_flag, double_speed}))
      else $error("flag or speed moved unasked");
   a_ram_route: assert property ((on_chip_expanded_ram || ext_data_sel) == external_move
      && !(on_chip_expanded_ram && ext_data_sel)) else $error("bad move routing");
   a_strobe_gap: assert property (addr_latch_strobe |=> !addr_latch_strobe [*2])
      else $error("strobe too close");
   a_tick_bound: assert property (periph_tick |-> ##[1:12] periph_tick)
      else $error("tick late");
   a_std_period: assert property (periph_tick && !double_speed ##1 !double_speed [*8]
      ##1 !double_speed [*4] |-> periph_tick) else $error("standard period wrong");
   a_dbl_period: assert property (periph_tick && double_speed ##1 double_speed [*6]
      |-> periph_tick) else $error("double period wrong");
   c_inc: cover property (core_aux1_inc);
   c_move_strobe: cover property (addr_latch_strobe && external_move);
   c_dbl_tick: cover property (periph_tick && double_speed);
endmodule : dpac_sva
bind dpac_top dpac_sva i_dpac_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .core_aux1_inc(core_aux1_inc),
   .external_move(external_move), .pointer_select(pointer_select), .user_flag(user_flag),
   .addr_latch_strobe(addr_latch_strobe), .on_chip_expanded_ram(on_chip_expanded_ram),
   .ext_data_sel(ext_data_sel), .double_speed(double_speed), .periph_tick(periph_tick));

//--- dpac_core_model.sv
// Purpose: Behavioural instruction side feeding the core strobes
// Assumes: Tasks are entered just after a rising edge
// Notes: Pulse and load each leave one idle cycle behind them; move returns at once
`timescale 1ns/100ps
module dpac_core_model (
   input wire logic hclk,
   output logic core_aux1_inc,
   output logic core_ptr_load,
   output logic [15:0] core_ptr_data,
   output logic core_ptr_inc,
   output logic external_move,
   output logic code_move,
   output logic ext_data_access
);
   // ***********************
   // Instruction effects
   // ***********************
   // Idle core at time zero
   initial begin
      {core_aux1_inc, core_ptr_load, core_ptr_inc, external_move, code_move} = 5'h00;
      ext_data_access = 1'b0;
      core_ptr_data = 16'h0000;
   end
   // One-cycle pulse: 0 select increment, 1 pointer increment, 2 data access
   task automatic pulse(input int k);
      {core_aux1_inc, core_ptr_inc, ext_data_access} <= 3'h4 >> k;
      @(posedge hclk);
      #1;
      {core_aux1_inc, core_ptr_inc, ext_data_access} <= 3'h0;
      @(posedge hclk);
      #1;
   endtask : pulse
   // Pointer load; released data shows the inverse, not the old value
   task automatic load(input logic [15:0] d);
      core_ptr_data <= d;
      core_ptr_load <= 1'b1;
      @(posedge hclk);
      #1;
      core_ptr_load <= 1'b0;
      core_ptr_data <= ~d;
      @(posedge hclk);
      #1;
   endtask : load
   // Levels of the running move instruction
   task automatic move(input logic em, input logic cm);
      external_move <= em;
      code_move <= cm;
   endtask : move
endmodule : dpac_core_model

//--- dual_pointer_aux_control_tb.sv
// Purpose: Self-checking bench for dpac_top
// Assumes: Zero-wait slave; read data latched at the sampling edge
// Notes: Strobe counts over whole periods are phase independent
`timescale 1ns/100ps
`include "dpac_params.svh"
module dual_pointer_aux_control_tb;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sel_en;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd_q, v;
   logic core_aux1_inc, core_ptr_load, core_ptr_inc, external_move, code_move, ext_data_access;
   logic [15:0] core_ptr_data, data_pointer_reg;
   logic pointer_select, user_flag, addr_latch_strobe, on_chip_expanded_ram, ext_data_sel;
   logic double_speed, periph_tick;
   int fails, checks_done, n_st, n_tk;
   int exp_st [5] = '{20, 40, 0, 20, 18};
   dpac_top i_dpac_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_aux1_inc(core_aux1_inc),
      .core_ptr_load(core_ptr_load), .core_ptr_data(core_ptr_data), .core_ptr_inc(core_ptr_inc),
      .external_move(external_move), .code_move(code_move), .ext_data_access(ext_data_access),
      .data_pointer_reg(data_pointer_reg), .pointer_select(pointer_select),
      .user_flag(user_flag), .addr_latch_strobe(addr_latch_strobe),
      .on_chip_expanded_ram(on_chip_expanded_ram), .ext_data_sel(ext_data_sel),
      .double_speed(double_speed), .periph_tick(periph_tick));
   dpac_core_model i_dpac_core_model (.hclk(hclk), .core_aux1_inc(core_aux1_inc),
      .core_ptr_load(core_ptr_load), .core_ptr_data(core_ptr_data), .core_ptr_inc(core_ptr_inc),
      .external_move(external_move), .code_move(code_move), .ext_data_access(ext_data_access));
   // ***********************
   // Clock and bus tasks
   // ***********************
   // 40 MHz clock
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   // Read data as it stood at the edge, free of update races
   always @(posedge hclk) rd_q <= hrdata;
   task automatic close_out;
      if (fails == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Bounded wait for hready at a rising edge
   task automatic rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         #1;
         n++;
         if (n > 20) begin
            fails++;
            close_out;
         end
      end while (hreadyout !== 1'b1);
   endtask : rdy
   // One AHB single transfer; read data lands in v
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      hsel <= sel_en;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'h2;
      haddr <= {22'h000000, idx, 2'b00};
      rdy;
      // Select and size only qualify the address phase
      hsel <= 1'b0;
      hsize <= 3'h0;
      htrans <= 2'b00;
      hwdata <= d;
      rdy;
      v = rd_q;
   endtask : bus
   // Strobes and ticks seen over 120 cycles
   task automatic cnt;
      n_st = 0;
      n_tk = 0;
      repeat (120) begin
         @(posedge hclk);
         #1;
         n_st += (addr_latch_strobe === 1'b1);
         n_tk += (periph_tick === 1'b1);
      end
   endtask : cnt
   // Main sequence
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
      sel_en = 1'b1;
      fails = 0;
      checks_done = 0;
      repeat (6) @(posedge hclk);
      #1;
      hresetn <= 1'b1;
      bus(0, `DPAC_IDX_AUX1, 0);
      chk(v & 32'h09, 0);
      bus(0, `DPAC_IDX_AUX, 0);
      chk({v[1:0], double_speed}, 0);
      i_dpac_core_model.load(16'hA5C3);
      i_dpac_core_model.pulse(0);
      chk({pointer_select, data_pointer_reg}, 17'h10000);
      i_dpac_core_model.load(16'h12FF);
      i_dpac_core_model.pulse(1);
      i_dpac_core_model.pulse(0);
      chk({pointer_select, data_pointer_reg}, 17'h0A5C3);
      bus(0, `DPAC_IDX_PTR1, 0);
      chk(v[15:0], 16'h1300);
      bus(1, `DPAC_IDX_AUX1, 32'h09);
      bus(0, `DPAC_IDX_AUX1, 0);
      chk({v[3:0] & 4'h9, pointer_select, user_flag}, 6'h27);
      bus(1, 8'hFF, 32'hFFFFFFFF);
      bus(0, 8'hFF, 0);
      chk(v, 0);
      chk({hresp, hreadyout}, 2'h1);
      // A write without select must leave the flag alone
      sel_en = 1'b0;
      bus(1, `DPAC_IDX_AUX1, 0);
      sel_en = 1'b1;
      bus(0, `DPAC_IDX_AUX1, 0);
      chk(v[3:0], 4'h9);
      // Bus toggle of the select, then the current pointer view
      bus(1, `DPAC_IDX_PTR0, 32'h00005A5A);
      bus(1, `DPAC_IDX_TOGGLE, 0);
      bus(0, `DPAC_IDX_CURPTR, 0);
      chk({pointer_select, v[15:0]}, 17'h05A5A);
      chk(data_pointer_reg, 16'h5A5A);
      i_dpac_core_model.move(1, 0);
      for (int m = 0; m < 2; m++) begin
         bus(1, `DPAC_IDX_AUX, m << 1);
         chk({ext_data_sel, on_chip_expanded_ram}, m ? 2'h2 : 2'h1);
      end
      for (int k = 0; k < 5; k++) begin
         i_dpac_core_model.move(0, k == 3);
         bus(1, `DPAC_IDX_AUX, (k == 2 || k == 3));
         bus(1, `DPAC_IDX_CLK, (k == 1));
         repeat (14) @(posedge hclk);
         #1;
         fork
            cnt;
            if (k == 4) begin
               i_dpac_core_model.pulse(2);
               repeat (20) @(posedge hclk);
               #1;
               i_dpac_core_model.pulse(2);
            end
         join
         chk(n_st, exp_st[k]);
         chk(n_tk, (k == 1) ? 20 : 10);
      end
      // Reset in mid-run clears flag, select, speed and both pointers
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      #1;
      chk({user_flag, pointer_select, double_speed, data_pointer_reg}, 19'h0);
      hresetn <= 1'b1;
      bus(0, `DPAC_IDX_PTR1, 0);
      chk(v, 0);
      close_out;
   end
endmodule : dual_pointer_aux_control_tb
